// ===== hdl/scs_pkg.sv
// Package with register map, field positions, codes and carrier types
package scs_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] TXD_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] RXD_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] CARD_OFS = 8'h14;

	// Control register fields
	localparam int unsigned CTRL_TIE_BIT = 7;
	localparam int unsigned CTRL_RIE_BIT = 6;
	localparam int unsigned CTRL_TE_BIT = 5;
	localparam int unsigned CTRL_RE_BIT = 4;
	localparam int unsigned CTRL_MULTIPROC_IRQ_ENABLE_BIT = 3;
	localparam int unsigned CTRL_TX_END_IRQ_ENABLE_BIT = 2;
	localparam int unsigned CTRL_CKE_HI_BIT = 1;
	localparam int unsigned CTRL_CKE_LO_BIT = 0;

	// Status register fields
	localparam int unsigned STAT_TX_EMPTY_FLAG_BIT = 7;
	localparam int unsigned STAT_RX_FULL_FLAG_BIT = 6;
	localparam int unsigned STAT_OVERRUN_FLAG_BIT = 5;
	localparam int unsigned STAT_FER_BIT = 4;
	localparam int unsigned STAT_PER_BIT = 3;

	// Mode and card mode register fields
	localparam int unsigned MODE_GM_BIT = 7;
	localparam int unsigned MODE_PAR_BIT = 5;
	localparam int unsigned CARD_SEL_BIT = 0;
	localparam int unsigned CARD_PIN_BIT = 7;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CARD_RST = 8'h00;
	localparam logic TX_EMPTY_FLAG_RST = 1'b1;
	localparam logic RX_FULL_FLAG_RST = 1'b0;

	// Clock enable field codes
	localparam logic [1:0] CKE_PORT = 2'h0;
	localparam logic [1:0] CKE_CLOCK = 2'h1;
	localparam logic [1:0] CKE_HIGH = 2'h2;

	// Link frame: start, 8 data, parity, stop
	localparam logic [3:0] FRAME_BITS = 4'hB;
	localparam logic [3:0] RX_LAST = 4'h9;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADDR_W-1:0] adr;
		logic [DATA_W-1:0] dat;
	} scs_wb_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic par_en;
	} scs_tx_word_t;

	typedef struct packed {
		logic [7:0] data;
		logic framing_error_flag;
		logic parity_error_flag;
	} scs_rx_word_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} scs_tx_st_t;

	typedef enum logic {
		RX_IDLE = 1'b0,
		RX_RECV = 1'b1
	} scs_rx_st_t;
endpackage

// ===== hdl/scs_serial_ctrl.sv
// Serial channel control and status registers with link shifters
// Functional notes
// - In card mode the transmit-needed request rises only with control bit 7 set.
// - In card mode receive-full and receive-error requests need control bit 6 set.
// - Control bit 5 enables transmit, bit 4 enables receive; both reset low.
// - Enables take a 1 only while both are 0; afterwards only both-clear.
// - Clock-enable bits are writable only while both enables are 0.
// - Timing option clear: 00 port, 01 clock out, 1x reserved.
// - Timing option set (card mode): 00 low, 10 high, x1 clock out; locked while an enable is 1.
// - Select bit 1 gives card meanings; 0 gives normal serial meanings.
// - Status flags are only cleared by software writes, never set.
// - Transmit-empty resets to 1 and stays 1 while transmit is disabled.
// - Transmit-empty sets when the holding byte moves into the shift stage.
// - Transmit-empty clears by writing 0 after reading it as 1.
// - Receive-full resets 0, sets when a good byte moves to holding register.
// - Receive-full clears by writing 0 after reading it as 1.
// - Clearing receive enable leaves receive-full unchanged.
// - Reception completing while receive-full is 1 flags overrun, drops the byte.
// - On overrun the old byte stays and reception stops until overrun clears.
`timescale 1ns/100ps
module scs_serial_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire scs_pkg::scs_wb_req_t wb_i,
	output logic wb_ack_o,
	output logic [scs_pkg::DATA_W-1:0] wb_dat_o,
	output logic tx_needed_irq_o,
	output logic rx_full_irq_o,
	output logic rx_error_irq_o,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n_o,
	input wire logic rxd_i,
	output logic txd_o
);
	import scs_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// Pin drive: {oe_n, level}
	function automatic logic [1:0] sck_drive(input logic smartcard_select, input logic gm,
			input logic [1:0] cke, input logic clk_lvl);
		logic [1:0] r;
		r = {1'b1, 1'b1};
		if (smartcard_select && gm) begin
			r = {1'b0, cke[0] ? clk_lvl : (cke == CKE_HIGH)};
		end else if (cke == CKE_CLOCK) begin
			r = {1'b0, clk_lvl};
		end
		return r;
	endfunction

	logic ack_q, tx_empty_flag_q, rx_full_flag_q, overrun_flag_q, fer_q, per_q, txi_q, rxi_q, eri_q;
	logic div_q, sck_q, sck_oe_n_q, sck_s1_q, sck_s2_q;
	logic [DATA_W-1:0] dat_q, rdata_d;
	logic [7:0] ctrl_q, mode_q, card_q, tx_hold_q, rx_hold_q, wd;
	logic [4:0] arm_q, flags, clr;
	logic req, wr, rd, locked, smartcard_select, par_en, tx_busy, tx_load, rx_evt, rx_accept;
	// Core side of crossings
	scs_tx_word_t tx_xfer_q;
	logic tx_req_q, tx_ack_s1_q, tx_ack_s2_q, rx_tog_s1_q, rx_tog_s2_q, rx_tog_s3_q;
	// Link side
	logic lrst_s1_q, lrst_s2_q, l_req_s1_q, l_req_s2_q, l_seen_q, l_tx_ack_q, l_txd_q;
	logic l_rxd_s1_q, l_rxd_s2_q, l_ack_s1_q, l_ack_s2_q, l_par_s1_q, l_par_s2_q, l_rx_tog_q;
	scs_tx_st_t l_tx_st_q;
	scs_rx_st_t l_rx_st_q;
	logic [10:0] l_tx_sh_q;
	logic [9:0] l_rx_sh_q;
	logic [3:0] l_tx_cnt_q, l_rx_cnt_q;
	scs_rx_word_t l_rx_word_q;

	assign req = wb_i.cyc & wb_i.stb & ~ack_q;
	assign wr = req & wb_i.we & wb_i.sel[0];
	assign rd = req & ~wb_i.we;
	assign wd = wb_i.dat[7:0];
	assign locked = ctrl_q[CTRL_TE_BIT] | ctrl_q[CTRL_RE_BIT];
	assign smartcard_select = card_q[CARD_SEL_BIT];
	assign par_en = mode_q[MODE_PAR_BIT] | smartcard_select;
	assign tx_busy = tx_req_q ^ tx_ack_s2_q;
	assign tx_load = ctrl_q[CTRL_TE_BIT] & ~tx_empty_flag_q & ~tx_busy;
	assign rx_evt = rx_tog_s2_q ^ rx_tog_s3_q;
	assign rx_accept = rx_evt & ctrl_q[CTRL_RE_BIT] & ~overrun_flag_q & ~fer_q;
	assign flags = {tx_empty_flag_q, rx_full_flag_q, overrun_flag_q, fer_q, per_q};
	assign clr = (wr && hit(wb_i.adr, STAT_OFS)) ? (arm_q & ~{wd[STAT_TX_EMPTY_FLAG_BIT],
		wd[STAT_RX_FULL_FLAG_BIT], wd[STAT_OVERRUN_FLAG_BIT], wd[STAT_FER_BIT], wd[STAT_PER_BIT]}) : 5'h00;

	// Bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= req;
			if (rd) begin
				dat_q <= rdata_d;
			end
		end
	end

	always_comb begin
		rdata_d = '0;
		case (wb_i.adr)
			MODE_OFS: rdata_d[7:0] = mode_q;
			CTRL_OFS: rdata_d[7:0] = ctrl_q;
			TXD_OFS: rdata_d[7:0] = tx_hold_q;
			STAT_OFS: rdata_d[7:0] = {flags, 3'h0};
			RXD_OFS: rdata_d[7:0] = rx_hold_q;
			CARD_OFS: rdata_d[7:0] = {sck_s2_q, card_q[6:0]};
			default: rdata_d = '0;
		endcase
	end

	// Control register with write locks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
		end else if (wr && hit(wb_i.adr, CTRL_OFS)) begin
			ctrl_q[7:6] <= wd[7:6];
			ctrl_q[3:2] <= wd[3:2];
			if (!locked) begin
				ctrl_q[CTRL_TE_BIT:CTRL_RE_BIT] <= wd[CTRL_TE_BIT:CTRL_RE_BIT];
				ctrl_q[CTRL_CKE_HI_BIT:CTRL_CKE_LO_BIT] <= wd[1:0];
			end else if (wd[CTRL_TE_BIT:CTRL_RE_BIT] == 2'h0) begin
				ctrl_q[CTRL_TE_BIT:CTRL_RE_BIT] <= 2'h0;
			end
		end
	end

	// Mode, card mode and transmit holding registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= MODE_RST;
			card_q <= CARD_RST;
			tx_hold_q <= 8'h00;
		end else if (wr) begin
			if (hit(wb_i.adr, MODE_OFS)) begin
				mode_q <= wd;
			end
			if (hit(wb_i.adr, CARD_OFS)) begin
				card_q <= wd;
			end
			if (hit(wb_i.adr, TXD_OFS)) begin
				tx_hold_q <= wd;
			end
		end
	end

	// Read-as-one tracking for flag clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arm_q <= 5'h00;
		end else if (req && hit(wb_i.adr, STAT_OFS)) begin
			arm_q <= rd ? flags : 5'h00;
		end
	end

	// Transmit-empty flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_empty_flag_q <= TX_EMPTY_FLAG_RST;
		end else if (!ctrl_q[CTRL_TE_BIT]) begin
			tx_empty_flag_q <= 1'b1;
		end else if (tx_load) begin
			tx_empty_flag_q <= 1'b1;
		end else if (clr[4]) begin
			tx_empty_flag_q <= 1'b0;
		end
	end

	// Hand the holding byte to the link shifter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_req_q <= 1'b0;
			tx_xfer_q <= '0;
			tx_ack_s1_q <= 1'b0;
			tx_ack_s2_q <= 1'b0;
		end else begin
			tx_ack_s1_q <= l_tx_ack_q;
			tx_ack_s2_q <= tx_ack_s1_q;
			if (tx_load) begin
				tx_xfer_q <= '{data: tx_hold_q, par_en: par_en};
				tx_req_q <= ~tx_req_q;
			end
		end
	end

	// Receive event crossing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_tog_s1_q <= 1'b0;
			rx_tog_s2_q <= 1'b0;
			rx_tog_s3_q <= 1'b0;
		end else begin
			rx_tog_s1_q <= l_rx_tog_q;
			rx_tog_s2_q <= rx_tog_s1_q;
			rx_tog_s3_q <= rx_tog_s2_q;
		end
	end

	// Receive flags and holding register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_full_flag_q <= RX_FULL_FLAG_RST;
			overrun_flag_q <= 1'b0;
			fer_q <= 1'b0;
			per_q <= 1'b0;
			rx_hold_q <= 8'h00;
		end else begin
			if (rx_accept && rx_full_flag_q) begin
				overrun_flag_q <= 1'b1;
			end else if (clr[2]) begin
				overrun_flag_q <= 1'b0;
			end
			if (rx_accept && !rx_full_flag_q && l_rx_word_q.framing_error_flag) begin
				fer_q <= 1'b1;
			end else if (clr[1]) begin
				fer_q <= 1'b0;
			end
			if (rx_accept && !rx_full_flag_q && !l_rx_word_q.framing_error_flag && l_rx_word_q.parity_error_flag) begin
				per_q <= 1'b1;
			end else if (clr[0]) begin
				per_q <= 1'b0;
			end
			if (rx_accept && !rx_full_flag_q && !l_rx_word_q.framing_error_flag && !l_rx_word_q.parity_error_flag) begin
				rx_full_flag_q <= 1'b1;
			end else if (clr[3]) begin
				rx_full_flag_q <= 1'b0;
			end
			if (rx_accept && !rx_full_flag_q) begin
				rx_hold_q <= l_rx_word_q.data;
			end
		end
	end

	// Request outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txi_q <= 1'b0;
			rxi_q <= 1'b0;
			eri_q <= 1'b0;
		end else begin
			txi_q <= tx_empty_flag_q & ctrl_q[CTRL_TIE_BIT];
			rxi_q <= rx_full_flag_q & ctrl_q[CTRL_RIE_BIT];
			eri_q <= (overrun_flag_q | fer_q | per_q) & ctrl_q[CTRL_RIE_BIT];
		end
	end

	// Serial clock pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= 1'b0;
			sck_q <= 1'b1;
			sck_oe_n_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
			sck_s1_q <= sck_i;
			sck_s2_q <= sck_s1_q;
			{sck_oe_n_q, sck_q} <= sck_drive(smartcard_select, mode_q[MODE_GM_BIT],
				ctrl_q[CTRL_CKE_HI_BIT:CTRL_CKE_LO_BIT], div_q);
		end
	end

	// Link reset and level synchronisers
	always_ff @(posedge link_clk_i) begin
		lrst_s1_q <= rst_i;
		lrst_s2_q <= lrst_s1_q;
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst_s2_q) begin
			l_req_s1_q <= 1'b0;
			l_req_s2_q <= 1'b0;
			l_rxd_s1_q <= 1'b1;
			l_rxd_s2_q <= 1'b1;
			l_ack_s1_q <= 1'b0;
			l_ack_s2_q <= 1'b0;
			l_par_s1_q <= 1'b0;
			l_par_s2_q <= 1'b0;
		end else begin
			l_req_s1_q <= tx_req_q;
			l_req_s2_q <= l_req_s1_q;
			l_rxd_s1_q <= rxd_i;
			l_rxd_s2_q <= l_rxd_s1_q;
			l_ack_s1_q <= rx_tog_s3_q;
			l_ack_s2_q <= l_ack_s1_q;
			l_par_s1_q <= par_en;
			l_par_s2_q <= l_par_s1_q;
		end
	end

	// Link transmit shifter
	always_ff @(posedge link_clk_i) begin
		if (lrst_s2_q) begin
			l_tx_st_q <= TX_IDLE;
			l_seen_q <= 1'b0;
			l_tx_ack_q <= 1'b0;
			l_tx_sh_q <= '1;
			l_tx_cnt_q <= 4'h0;
			l_txd_q <= 1'b1;
		end else begin
			unique case (l_tx_st_q)
				TX_IDLE: begin
					l_txd_q <= 1'b1;
					if (l_req_s2_q != l_seen_q) begin
						l_seen_q <= l_req_s2_q;
						l_tx_sh_q <= {1'b1, tx_xfer_q.par_en ? ^tx_xfer_q.data : 1'b1,
							tx_xfer_q.data, 1'b0};
						l_tx_cnt_q <= FRAME_BITS;
						l_tx_st_q <= TX_SEND;
					end
				end
				TX_SEND: begin
					l_txd_q <= l_tx_sh_q[0];
					l_tx_sh_q <= {1'b1, l_tx_sh_q[10:1]};
					l_tx_cnt_q <= l_tx_cnt_q - 4'h1;
					if (l_tx_cnt_q == 4'h1) begin
						l_tx_ack_q <= l_seen_q;
						l_tx_st_q <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// Link receive shifter
	always_ff @(posedge link_clk_i) begin
		if (lrst_s2_q) begin
			l_rx_st_q <= RX_IDLE;
			l_rx_sh_q <= '0;
			l_rx_cnt_q <= 4'h0;
			l_rx_word_q <= '0;
			l_rx_tog_q <= 1'b0;
		end else begin
			unique case (l_rx_st_q)
				RX_IDLE: begin
					if (!l_rxd_s2_q && l_rx_tog_q == l_ack_s2_q) begin
						l_rx_cnt_q <= 4'h0;
						l_rx_st_q <= RX_RECV;
					end
				end
				RX_RECV: begin
					l_rx_sh_q <= {l_rxd_s2_q, l_rx_sh_q[9:1]};
					l_rx_cnt_q <= l_rx_cnt_q + 4'h1;
					if (l_rx_cnt_q == RX_LAST) begin
						l_rx_word_q.data <= l_rx_sh_q[8:1];
						l_rx_word_q.framing_error_flag <= ~l_rxd_s2_q;
						l_rx_word_q.parity_error_flag <= l_par_s2_q & (l_rx_sh_q[9] ^ (^l_rx_sh_q[8:1]));
						l_rx_tog_q <= ~l_rx_tog_q;
						l_rx_st_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign tx_needed_irq_o = txi_q;
	assign rx_full_irq_o = rxi_q;
	assign rx_error_irq_o = eri_q;
	assign sck_o = sck_q;
	assign sck_oe_n_o = sck_oe_n_q;
	assign txd_o = l_txd_q;
endmodule

// ===== verification/scs_serial_ctrl_asserts.sv
// Checker for the serial control block ports
`timescale 1ns/100ps
module scs_serial_ctrl_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire scs_pkg::scs_wb_req_t wb_i,
	input wire logic wb_ack_o,
	input wire logic [scs_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic tx_needed_irq_o,
	input wire logic rx_full_irq_o,
	input wire logic rx_error_irq_o,
	input wire logic sck_i,
	input wire logic sck_o,
	input wire logic sck_oe_n_o,
	input wire logic rxd_i,
	input wire logic txd_o
);
	import scs_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_i.cyc && wb_i.stb && !wb_ack_o;
	endsequence
	sequence s_wr;
		wb_ack_o && wb_i.we;
	endsequence
	property p_fall(logic s);
		$fell(s) |-> $past(wb_ack_o && wb_i.we);
	endproperty
	a_ack_answer: assert property (s_req |=> wb_ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_i.cyc && wb_i.stb))
		else $error("ack without request");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper data bits set");
	a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_i.we)
		else $error("read data moved");
	a_rst_idle: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i && $past(rst_i, 2) |-> sck_o && sck_oe_n_o && txd_o && !rx_error_irq_o)
		else $error("outputs not idle in reset");
	a_txirq_fall: assert property (p_fall(tx_needed_irq_o))
		else $error("tx request fell alone");
	a_rxirq_fall: assert property (p_fall(rx_full_irq_o))
		else $error("rx request fell alone");
	a_errirq_fall: assert property (p_fall(rx_error_irq_o))
		else $error("error request fell alone");
	c_write: cover property (s_wr);
endmodule

// ===== verification/scs_peer.sv
// Serial peer model: sends frames and captures sent frames
`timescale 1ns/100ps
module scs_peer (
	input wire logic link_clk_i,
	input wire logic txd_i,
	output logic rxd_o,
	output logic [9:0] got_o
);
	task automatic send(input logic [7:0] b, input logic stp);
		logic [10:0] f;
		f = {stp, 1'b1, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge link_clk_i);
			rxd_o <= f[i];
		end
		@(posedge link_clk_i);
		rxd_o <= 1'b1;
	endtask
	initial begin
		rxd_o = 1'b1;
		got_o = '0;
		forever begin
			@(negedge txd_i);
			for (int i = 0; i < 10; i++) begin
				@(posedge link_clk_i);
				@(negedge link_clk_i);
				got_o = {txd_i, got_o[9:1]};
			end
		end
	end
endmodule

// ===== verification/tb_top.sv
// Testbench for the serial control block
`timescale 1ns/100ps
module tb_top;
	import scs_pkg::*;
	logic clk_i, rst_i, link_clk_i, sck_i, rxd_i, txd_o, wb_ack_o;
	logic tx_needed_irq_o, rx_full_irq_o, rx_error_irq_o, sck_o, sck_oe_n_o;
	logic [DATA_W-1:0] wb_dat_o;
	logic [2:0] irqs;
	logic [9:0] got;
	logic [7:0] rd;
	scs_wb_req_t wb_i;
	int err_count, samples_checked;
	assign irqs = {tx_needed_irq_o, rx_full_irq_o, rx_error_irq_o};
	assign sck_i = sck_oe_n_o ? 1'b1 : sck_o;
	scs_serial_ctrl uut (.clk_i, .rst_i, .link_clk_i, .wb_i, .wb_ack_o, .wb_dat_o,
		.tx_needed_irq_o, .rx_full_irq_o, .rx_error_irq_o, .sck_i, .sck_o,
		.sck_oe_n_o, .rxd_i, .txd_o);
	scs_peer u_peer (.link_clk_i, .txd_i(txd_o), .rxd_o(rxd_i), .got_o(got));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#2.1;
		forever #3 link_clk_i = ~link_clk_i;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb_i <= '{1'b1, 1'b1, w, 4'hF, a, {24'h000000, d}};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o[7:0];
		wb_i.cyc <= 1'b0;
		wb_i.stb <= 1'b0;
		if (n == 50) chk(8'h00, 8'h01, "no ack");
		@(posedge clk_i);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
		bus(1'b0, a, 8'h00);
		chk(rd, e, m);
	endtask
	task automatic wirq(input int k);
		int n;
		n = 0;
		while (irqs[k] !== 1'b1 && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		chk({7'h00, irqs[k]}, 8'h01, "irq");
	endtask
	task automatic clr_stat();
		bus(1'b0, STAT_OFS, 8'h00);
		bus(1'b1, STAT_OFS, 8'h00);
	endtask
	task automatic t_reset();
		rchk(STAT_OFS, 8'h80, "stat rst");
		rchk(CTRL_OFS, CTRL_RST, "ctrl rst");
		rchk(8'h1C, 8'h00, "unmapped");
		rchk(CARD_OFS, 8'h80, "pin idle");
		bus(1'b1, STAT_OFS, 8'hFF);
		clr_stat();
		rchk(STAT_OFS, 8'h80, "stat held");
		$display("t_reset done");
	endtask
	task automatic t_lock();
		bus(1'b1, CTRL_OFS, 8'h20);
		rchk(CTRL_OFS, 8'h20, "te set");
		bus(1'b1, CTRL_OFS, 8'h13);
		rchk(CTRL_OFS, 8'h20, "locked");
		bus(1'b1, CTRL_OFS, 8'hC0);
		rchk(CTRL_OFS, 8'hC0, "both clear");
		bus(1'b1, CTRL_OFS, 8'h03);
		rchk(CTRL_OFS, 8'h03, "cke open");
		bus(1'b1, CTRL_OFS, 8'h00);
		$display("t_lock done");
	endtask
	task automatic t_tx();
		bus(1'b1, MODE_OFS, 8'h20);
		bus(1'b1, STAT_OFS, 8'h00);
		bus(1'b1, CTRL_OFS, 8'hA0);
		wirq(2);
		bus(1'b1, TXD_OFS, 8'h5A);
		bus(1'b1, STAT_OFS, 8'h00);
		rchk(STAT_OFS, 8'h80, "clear unarmed");
		chk({7'h00, irqs[2]}, 8'h01, "tx irq kept");
		clr_stat();
		wirq(2);
		repeat (10) @(posedge clk_i);
		chk(got[7:0], 8'h5A, "tx byte");
		chk({6'h00, got[9:8]}, 8'h02, "tx tail");
		bus(1'b1, CTRL_OFS, 8'h00);
		bus(1'b1, MODE_OFS, 8'h00);
		rchk(STAT_OFS, 8'h80, "tx off");
		$display("t_tx done");
	endtask
	task automatic t_rx();
		bus(1'b1, CTRL_OFS, 8'h50);
		u_peer.send(8'hA5, 1'b1);
		wirq(1);
		rchk(STAT_OFS, 8'hC0, "rx full");
		rchk(RXD_OFS, 8'hA5, "rx byte");
		u_peer.send(8'h3C, 1'b1);
		wirq(0);
		rchk(STAT_OFS, 8'hE0, "overrun");
		rchk(RXD_OFS, 8'hA5, "kept");
		bus(1'b1, CTRL_OFS, 8'h40);
		rchk(STAT_OFS, 8'hE0, "re off");
		clr_stat();
		rchk(STAT_OFS, 8'h80, "rx clr");
		bus(1'b1, CTRL_OFS, 8'h00);
		bus(1'b1, CTRL_OFS, 8'h50);
		u_peer.send(8'h11, 1'b0);
		wirq(0);
		rchk(STAT_OFS, 8'h90, "framing");
		clr_stat();
		bus(1'b1, CTRL_OFS, 8'h00);
		$display("t_rx done");
	endtask
	task automatic t_sck();
		logic s0;
		bus(1'b1, CTRL_OFS, 8'h01);
		s0 = sck_o;
		@(posedge clk_i);
		chk({6'h00, sck_oe_n_o, s0 ^ sck_o}, 8'h01, "clk out");
		bus(1'b1, CARD_OFS, 8'h01);
		bus(1'b1, MODE_OFS, 8'h80);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, CTRL_OFS, {6'h00, i[1:0]});
			s0 = sck_o;
			@(posedge clk_i);
			chk({6'h00, !sck_oe_n_o, i[0] ? s0 ^ sck_o : sck_o},
				{6'h00, 1'b1, i[0] | i[1]}, "card pin");
		end
		bus(1'b1, MODE_OFS, 8'h00);
		bus(1'b1, CTRL_OFS, 8'h02);
		chk({7'h00, sck_oe_n_o}, 8'h01, "reserved");
		bus(1'b1, CTRL_OFS, 8'h00);
		bus(1'b1, CARD_OFS, 8'h00);
		$display("t_sck done");
	endtask
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200us;
		err_count++;
		stop_test();
	end
	initial begin
		err_count = 0;
		samples_checked = 0;
		rst_i = 1'b1;
		wb_i = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_lock();
		t_tx();
		t_rx();
		t_sck();
		stop_test();
	end
endmodule
bind scs_serial_ctrl scs_serial_ctrl_asserts u_chk (.clk_i, .rst_i, .link_clk_i, .wb_i,
	.wb_ack_o, .wb_dat_o, .tx_needed_irq_o, .rx_full_irq_o, .rx_error_irq_o, .sck_i,
	.sck_o, .sck_oe_n_o, .rxd_i, .txd_o);
